// ---- ivt_timer.sv ----
// 8-bit interval, PWM and carrier compare timer with its registers
`timescale 1ns/10ps
module ivt_timer
  import ivt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  input  wire logic       low_speed_osc_clock,
  input  wire logic       partner_irq,
  output logic            match_interrupt,
  output logic            timer_output_pin,
  output logic [7:0]      port1_oe
);
  // ==========================================================
  // registers
  mode_ctl_t  mode;
  logic [7:0] port1_direction;
  logic [7:0] period_compare;
  logic [7:0] duty_buf;
  logic [7:0] duty_compare;
  logic       duty_pend;
  logic       remote_mode_bit;
  logic       carrier_gate_buffer;
  logic       carrier_gate_status;
  logic       gate_pend;
  // counting state
  logic [PRE_W-1:0] pre;
  logic [RL_W-1:0]  rl_div;
  logic             rl_prev;
  logic             started;
  logic [7:0]       cnt;
  phase_t           phase;
  logic             level;
  logic             run;
  logic             wr_mode;
  logic             wr_duty;
  logic             rl_edge;
  logic             tick;
  logic             cnt_tick;
  logic [7:0]       cmp_val;
  logic             hit;
  logic             irq_hit;
  logic             next_pin;

  // every check in this block runs on the one clock and rests during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // one address decoder for the mode, duty and carrier strobes keeps their map in one place
  function automatic logic reg_hit(input logic        stb,
                                   input logic [15:0] a,
                                   input logic [15:0] want);
    reg_hit = stb && a == want;
  endfunction

  // register strobes and the run bit
  assign run     = mode.run_enable_bit;
  assign wr_mode = reg_hit(req.wr, req.addr, ADDR_MODE);
  assign wr_duty = reg_hit(req.wr, req.addr, ADDR_DUTY);

  // count clock enable from the selected division
  function automatic logic sel_tick(input logic [2:0] sel,
                                    input logic [PRE_W-1:0] p,
                                    input logic [RL_W-1:0] r,
                                    input logic e);
    case (sel)
      3'h0:    sel_tick = 1'b1;
      3'h1:    sel_tick = &p[1:0];
      3'h2:    sel_tick = &p[3:0];
      3'h3:    sel_tick = &p[5:0];
      3'h4:    sel_tick = &p[PRE_W-1:0];
      3'h5:    sel_tick = e & (&r[6:0]);
      3'h6:    sel_tick = e & (&r[RL_W-1:0]);
      default: sel_tick = e;
    endcase
  endfunction

  // ==========================================================
  // mode register; full value taken on every write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= mode_ctl_t'(RST_MODE); // [R02]
    end else if (wr_mode) begin
      mode <= mode_ctl_t'(req.wdata); // [R06]
    end
  end

  // port direction and period compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port1_direction <= RST_PORT1_DIR; // [R12]
      period_compare  <= RST_CMP; // [R21]
    end else if (req.wr) begin
      if (req.addr == ADDR_PORT1_DIR) begin
        port1_direction <= req.wdata;
      end
      if (req.addr == ADDR_PERIOD) begin
        period_compare <= req.wdata; // [R21] [R20]
      end
    end
  end

  // duty compare: direct while stopped, else held until old value matches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duty_buf     <= RST_CMP;
      duty_compare <= RST_CMP;
      duty_pend    <= 1'b0;
    end else if (wr_duty) begin
      duty_buf <= req.wdata;
      if (!run) begin
        duty_compare <= req.wdata; // [R07]
        duty_pend    <= 1'b0;
      end else begin
        duty_pend <= 1'b1;
      end
    end else if (duty_pend && hit && phase == PH_DUTY) begin
      // a write in the match cycle loses the transfer on purpose
      duty_compare <= duty_buf;
      duty_pend    <= 1'b0;
    end
  end

  // carrier control register, writable fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {remote_mode_bit, carrier_gate_buffer} <= RST_CARRIER[2:1]; // [R09]
    end else if (reg_hit(req.wr, req.addr, ADDR_CARRIER)) begin
      {remote_mode_bit, carrier_gate_buffer} <= req.wdata[2:1];
    end
  end

  // gate status: partner event latched, moved on next count clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_gate_status <= RST_CARRIER[0];
      gate_pend           <= 1'b0;
    end else if (!run) begin
      carrier_gate_status <= carrier_gate_buffer; // [R11]
      gate_pend           <= 1'b0;
    end else begin
      // a new partner event wins over the consuming tick
      gate_pend <= partner_irq | (gate_pend & ~tick); // [R08]
      if (gate_pend && tick) begin
        carrier_gate_status <= carrier_gate_buffer; // [R11]
      end
    end
  end

  // while running the gate only moves on a handed-over partner event
  AST_GATE_HOLD: assert property (run && !gate_pend // [R11]
      |=> carrier_gate_status == $past(carrier_gate_status))
    else $error("gate status moved without partner event");

  // ==========================================================
  // prescalers; free running so the ratio stays exact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre     <= '0;
      rl_div  <= '0;
      rl_prev <= 1'b0;
    end else begin
      pre     <= pre + 1'b1;
      rl_prev <= low_speed_osc_clock;
      if (rl_edge) begin
        rl_div <= rl_div + 1'b1;
      end
    end
  end

  assign rl_edge  = low_speed_osc_clock & ~rl_prev;
  assign tick     = sel_tick(mode.clk_sel, pre, rl_div, rl_edge); // [R03]
  assign cnt_tick = run && started && tick; // [R22]
  // interval mode never enters the duty phase
  assign cmp_val  = (phase == PH_DUTY) ? duty_compare : period_compare; // [R15]
  assign hit      = cnt_tick && cnt == cmp_val;
  assign irq_hit  = hit && (phase == PH_PERIOD || mode.op_mode == MODE_CARRIER);

  // first count clock after start is masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      started <= 1'b0;
    end else if (!run) begin
      started <= 1'b0;
    end else if (tick) begin
      started <= 1'b1; // [R17]
    end
  end

  // the masked first tick must leave the counter at zero
  AST_MASKED_TICK: assert property (run && !started |=> cnt == 8'h00) // [R17]
    else $error("counter moved on the masked tick");

  // ==========================================================
  // counter, phase and output level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt   <= 8'h00;
      phase <= PH_IDLE;
      level <= 1'b0;
    end else if (!run) begin
      cnt   <= 8'h00; // [R01]
      phase <= PH_IDLE;
      level <= (mode.op_mode == MODE_CARRIER) ? 1'b0 : mode.default_out_level; // [R19]
    end else begin
      if (phase == PH_IDLE) begin
        phase <= PH_PERIOD;
      end
      if (hit) begin
        level <= ~level; // [R18]
        case (mode.op_mode)
          MODE_PWM: begin
            phase <= (phase == PH_DUTY) ? PH_PERIOD : PH_DUTY;
            cnt   <= (phase == PH_DUTY) ? cnt + 8'h01 : 8'h00;
          end
          MODE_CARRIER: begin
            phase <= (phase == PH_DUTY) ? PH_PERIOD : PH_DUTY;
            cnt   <= 8'h00;
          end
          default: begin
            cnt <= 8'h00; // [R14] [R16]
          end
        endcase
      end else if (cnt_tick) begin
        cnt <= cnt + 8'h01; // [R22]
      end
    end
  end

  // counter steps by one per enabled tick without a match, holds without a tick
  AST_COUNT_STEP: assert property (cnt_tick && !hit |=> cnt == $past(cnt) + 8'h01) // [R22]
    else $error("counter did not step on a count clock");
  AST_COUNT_HOLD: assert property (run && !cnt_tick |=> cnt == $past(cnt)) // [R22]
    else $error("counter moved without a count clock");
  AST_PHASE_IDLE: assert property (!run |=> phase == PH_IDLE) // [R01]
    else $error("phase not idle while stopped");
  AST_BELOW_PERIOD: assert property (run && mode.op_mode == MODE_INTERVAL // [R14]
      |-> cnt <= period_compare)
    else $error("counter passed the period compare value");

  // one-cycle match pulse; low while stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_interrupt <= 1'b0;
    end else begin
      match_interrupt <= run && irq_hit; // [R14] [R18] [R19]
    end
  end

  // an interval-mode match pulse lasts one cycle, and no pulse shows while stopped
  AST_IRQ_PULSE: assert property (match_interrupt && mode.op_mode == MODE_INTERVAL // [R14]
      |=> !match_interrupt)
    else $error("match pulse longer than one cycle");
  AST_STOP_IRQ: assert property (!run |=> !match_interrupt) // [R19]
    else $error("match pulse while stopped");

  // pin level: carrier gating or square wave, else default level
  always_comb begin
    if (!mode.out_enable_bit) begin
      next_pin = mode.default_out_level; // [R04] [R05]
    end else if (mode.op_mode == MODE_CARRIER) begin
      next_pin = carrier_gate_status &
                 (remote_mode_bit ? (run & level) : 1'b1); // [R10]
    end else begin
      next_pin = level; // [R05]
    end
  end

  // registered so the pin never carries a decode glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= next_pin;
    end
  end

  // a disabled output rests at the default level in every mode
  AST_PIN_DISABLED: assert property (!mode.out_enable_bit && !wr_mode // [R04]
      |=> timer_output_pin == mode.default_out_level)
    else $error("disabled output not at default level");

  // buffers on while direction bit is zero
  assign port1_oe = ~port1_direction; // [R12] [R13]

  // ==========================================================
  // read data, registered; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_PORT1_DIR: rdata <= port1_direction;
        ADDR_MODE:      rdata <= mode;
        ADDR_CARRIER:   rdata <= {5'h00, remote_mode_bit,
                                  carrier_gate_buffer, carrier_gate_status}; // [R09]
        ADDR_PERIOD:    rdata <= period_compare;
        ADDR_DUTY:      rdata <= duty_compare;
        default:        rdata <= 8'h00;
      endcase
    end
  end

  // reads return the addressed register as it stood at the request edge
  AST_DIR_READ: assert property (req.rd && req.addr == ADDR_PORT1_DIR // [R12]
      |=> rdata == $past(port1_direction))
    else $error("direction register read wrong");
  AST_MODE_READ: assert property (req.rd && req.addr == ADDR_MODE // [R02]
      |=> rdata == $past(mode))
    else $error("mode register read wrong");

  // ==========================================================
  // checks
  AST_STOP_ZERO: assert property (!run |=> cnt == 8'h00) // [R01]
    else $error("counter not held at zero while stopped");
  AST_IRQ_CAUSE: assert property (match_interrupt && mode.op_mode == MODE_INTERVAL // [R14]
      |-> $past(cnt) == $past(period_compare) && $past(cnt_tick))
    else $error("interrupt without period match");
  AST_CLEAR: assert property (run && hit && mode.op_mode == MODE_INTERVAL // [R18]
      ##1 run |-> cnt == 8'h00)
    else $error("counter not cleared on match");
  AST_TOGGLE: assert property (run && hit && mode.op_mode == MODE_INTERVAL // [R05]
      && mode.out_enable_bit && !wr_mode |=> ##1 timer_output_pin != $past(timer_output_pin))
    else $error("square wave did not toggle");
  AST_STOP_DEFAULT: assert property (!run && !wr_mode && mode.op_mode != MODE_CARRIER // [R19]
      ##1 !wr_mode |=> !match_interrupt && timer_output_pin == mode.default_out_level)
    else $error("stopped timer not at default");
  AST_NO_DUTY: assert property (run && mode.op_mode == MODE_INTERVAL // [R15]
      |-> phase != PH_DUTY)
    else $error("duty phase in interval mode");
  AST_CARRIER_READ: assert property (req.rd && req.addr == ADDR_CARRIER // [R09]
      |=> rdata[7:3] == 5'h00 && rdata[0] == $past(carrier_gate_status))
    else $error("carrier register read wrong");
  AST_GATE_LOW: assert property (mode.out_enable_bit && mode.op_mode == MODE_CARRIER // [R10]
      && !carrier_gate_status && !wr_mode |=> !timer_output_pin)
    else $error("gated carrier not low");
  AST_START_MASK: assert property ($rose(run) |-> cnt == 8'h00 ##1 cnt == 8'h00) // [R17]
    else $error("count began without masked clock");

  COV_INTERVAL: cover property (run && irq_hit && mode.op_mode == MODE_INTERVAL);
  COV_PWM_DUTY: cover property (run && hit && phase == PH_DUTY && mode.op_mode == MODE_PWM);
  COV_CARRIER: cover property (run && carrier_gate_status && remote_mode_bit
      && mode.op_mode == MODE_CARRIER && hit);
  COV_GATE_XFER: cover property (run && gate_pend && tick);
  COV_STOP_RUN: cover property ($fell(run) && mode.op_mode == MODE_INTERVAL);
endmodule

// ---- ivt_pkg.sv ----
// constants and types for the 8-bit interval/carrier compare timer
// Function
// R01 - run bit low stops counter and holds it at zero; high lets it count
// R02 - mode register resets to zero; run, clock select, mode, level, enable fields
// R03 - clock select picks peripheral clock divisions or low-speed oscillator divisions
// R04 - default level bit sets idle level of timer output
// R05 - output enable gives 50 percent square wave in interval mode, else disabled
// R06 - software changes only run bit while timer is enabled
// R07 - software rewrites duty compare before each restart in PWM and carrier
// R08 - carrier mode needs count clock over six times partner timer clock
// R09 - carrier register resets to zero; upper bits read zero; gate status read-only
// R10 - remote bit and gate select low, high, low or carrier pulse
// R11 - gate status reads zero when carrier disabled, one when enabled
// R12 - direction bit zero drives pin, one releases it; resets to all ones
// R13 - software clears direction and latch bits to route timer output
// R14 - period match raises interrupt and clears counter, repeating
// R15 - duty compare ignored in interval mode
// R16 - interval is period compare plus one count clocks
// R17 - counting begins within one count clock after run is set
// R18 - period match toggles output, clears counter, interrupt on count clock
// R19 - clearing run returns interrupt and output to default levels; in carrier mode the output follows gate status and remote bit instead
// R20 - software keeps period compare within 01h to feh
// R21 - software writes period compare only while stopped; resets to zero
// R22 - counter increments once per selected count clock enable
package ivt_pkg;
  // ==========================================================
  // register addresses
  localparam logic [15:0] ADDR_PORT1_DIR = 16'hff21;
  localparam logic [15:0] ADDR_MODE      = 16'hff6c;
  localparam logic [15:0] ADDR_CARRIER   = 16'hff6d;
  localparam logic [15:0] ADDR_PERIOD    = 16'hff6e;
  localparam logic [15:0] ADDR_DUTY      = 16'hff6f;
  // ==========================================================
  // reset values and fields
  localparam logic [7:0] RST_PORT1_DIR = 8'hff;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [2:0] RST_CARRIER   = 3'h0;
  localparam logic [7:0] RST_CMP       = 8'h00;
  localparam int         PIN_TIMER_BIT = 6;
  localparam logic [1:0] MODE_INTERVAL = 2'h0;
  localparam logic [1:0] MODE_CARRIER  = 2'h1;
  localparam logic [1:0] MODE_PWM      = 2'h2;
  localparam int         PRE_W         = 12;
  localparam int         RL_W          = 9;
  // ==========================================================
  // types
  typedef struct packed {
    logic       run_enable_bit;
    logic [2:0] clk_sel;
    logic [1:0] op_mode;
    logic       default_out_level;
    logic       out_enable_bit;
  } mode_ctl_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_PERIOD = 2'b01,
    PH_DUTY   = 2'b11
  } phase_t;
endpackage

// ---- tb_top.sv ----
// self-checking bench for the 8-bit interval/carrier compare timer
`timescale 1ns/10ps
module tb_top;
  import ivt_pkg::*;
  // ==========================================================
  // stimulus, observed outputs and the design
  logic       clk;
  logic       rst;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       osc;
  logic       partner_irq;
  logic       irq;
  logic       pin;
  logic [7:0] oe;
  logic [1:0] osc_cnt = 2'h0;
  int         fails;
  int         check_count;

  ivt_timer dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .low_speed_osc_clock(osc), .partner_irq(partner_irq), .match_interrupt(irq),
    .timer_output_pin(pin), .port1_oe(oe));

  // slow oscillator stand-in: one rising edge every 4 clocks
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 2'h1;
  end
  assign osc = osc_cnt[1];

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write taken at the second edge; request held for exactly that edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  // read data is registered, so it is looked at after the taking edge settles
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // counts clocks until the interrupt pulse shows, bounded by lim
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask

  task automatic settle2;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic regs_task;
    rd_chk(ADDR_MODE, RST_MODE);
    rd_chk(ADDR_CARRIER, 8'h00);
    rd_chk(ADDR_PORT1_DIR, RST_PORT1_DIR);
    chk({8'h00, oe}, 16'h0000);
    rd_chk(16'hff70, 8'h00);
    wr(ADDR_PORT1_DIR, 8'hbf);
    #1;
    chk({8'h00, oe}, 16'h0040);
    rd_chk(ADDR_PORT1_DIR, 8'hbf);
    wr(ADDR_MODE, 8'h77);
    rd_chk(ADDR_MODE, 8'h77);
    wr(ADDR_MODE, 8'h00);
    // status bit ignores the write but follows the buffer while stopped
    wr(ADDR_CARRIER, 8'hfe);
    rd_chk(ADDR_CARRIER, 8'h07);
    wr(ADDR_CARRIER, 8'h01);
    rd_chk(ADDR_CARRIER, 8'h00);
  endtask

  task automatic run_interval(input logic [2:0] sel, input int div,
                              input logic [7:0] per, input logic lev);
    int   n;
    int   gap;
    logic p0;
    gap = (int'(per) + 1) * div;
    wr(ADDR_PERIOD, per);
    wr(ADDR_MODE, {1'b0, sel, MODE_INTERVAL, lev, 1'b1});
    settle2();
    chk({15'h0, pin}, {15'h0, lev});
    wr(ADDR_MODE, {1'b1, sel, MODE_INTERVAL, lev, 1'b1});
    wait_irq(2 * gap + 20, n);
    // masked tick, one step, then the match: pulse seen on the third edge
    if (sel == 3'h0 && per == 8'h01) begin
      chk(n[15:0], 16'd3);
    end
    p0 = pin;
    wait_irq(2 * gap + 20, n);
    chk(n[15:0], gap[15:0]);
    chk({15'h0, pin}, {15'h0, ~p0});
    // only the run bit changes on the way out
    wr(ADDR_MODE, {1'b0, sel, MODE_INTERVAL, lev, 1'b1});
    settle2();
    chk({15'h0, pin}, {15'h0, lev});
    wait_irq(gap + 20, n);
    chk({15'h0, irq}, 16'h0000);
  endtask

  // pwm: period match clears and pulses, duty match only toggles
  task automatic pwm_task;
    int n;
    int hi;
    wr(ADDR_PERIOD, 8'h03);
    wr(ADDR_MODE, {1'b0, 3'h0, MODE_PWM, 1'b0, 1'b1});
    wr(ADDR_DUTY, 8'h01);
    wr(ADDR_MODE, {1'b1, 3'h0, MODE_PWM, 1'b0, 1'b1});
    wait_irq(20, n);
    wait_irq(20, n);
    chk(n[15:0], 16'd4);
    // duty (1+1)/(3+1): half of two whole periods is high
    hi = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      hi += int'(pin === 1'b1);
    end
    chk(hi[15:0], 16'd4);
    wr(ADDR_MODE, {1'b0, 3'h0, MODE_PWM, 1'b0, 1'b1});
  endtask

  task automatic carrier_task;
    int hi;
    wr(ADDR_MODE, {1'b0, 3'h0, MODE_CARRIER, 1'b0, 1'b1});
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CARRIER, {5'h00, k[1:0], 1'b0});
      settle2();
      chk({15'h0, pin}, {15'h0, k == 1});
    end
    wr(ADDR_CARRIER, 8'h06);
    wr(ADDR_PERIOD, 8'h01);
    wr(ADDR_DUTY, 8'h01);
    wr(ADDR_MODE, {1'b1, 3'h0, MODE_CARRIER, 1'b0, 1'b1});
    hi = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      hi += int'(pin === 1'b1);
    end
    chk({15'h0, hi > 0 && hi < 40}, 16'h0001);
    // gate closes only when the partner event hands the buffer over
    wr(ADDR_CARRIER, 8'h04);
    @(posedge clk);
    partner_irq <= 1'b1;
    @(posedge clk);
    partner_irq <= 1'b0;
    repeat (4) @(posedge clk);
    hi = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      hi += int'(pin === 1'b1);
    end
    chk(hi[15:0], 16'h0000);
    rd_chk(ADDR_CARRIER, 8'h04);
    wr(ADDR_MODE, {1'b0, 3'h0, MODE_CARRIER, 1'b0, 1'b1});
  endtask

  // ==========================================================
  // verdict, clock, watchdog and main sequence
  task automatic tally_and_finish;
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // longest pass is the /4096 interval run, roughly 28k clocks
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    int divs[8];
    divs = '{1, 4, 16, 64, 4096, 512, 2048, 4};
    rst = 1'b1;
    req = '0;
    partner_irq = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    regs_task();
    for (int s = 0; s < 8; s++) begin
      run_interval(s[2:0], divs[s], 8'h01, 1'b0);
    end
    wr(ADDR_DUTY, 8'h00);
    run_interval(3'h0, 1, 8'h03, 1'b1);
    pwm_task();
    carrier_task();
    tally_and_finish();
  end
endmodule
